// >>> pcmtsp_pkg.sv
/*
  Constants, types and helpers shared by the PCM codec time-slot port.
  Assumes a 10 MHz system clock and bit clocks of at most about 2 MHz.
*/
package pcmtsp_pkg;

  // ==========================================================
  // Clocking and frame geometry
  localparam int unsigned MCLK_PERIOD_NS = 100;
  localparam int unsigned SLOT_BITS = 8;
  localparam int unsigned SLOT_W = 6;
  localparam int unsigned MAX_SLOTS = 32;
  localparam int unsigned BIT_CNT_W = 11;
  localparam logic [10:0] BIT_CNT_MAX = 11'h7FF;
  localparam logic [10:0] SLOT_ONE_START = 11'h001;
  localparam logic [10:0] SIG_DETECT_IDX = 11'h001;
  localparam logic [2:0] LAST_BIT_OFF = 3'h7;

  // ==========================================================
  // Conversion timing, in slots and nanoseconds
  localparam int unsigned ENC_DONE_SLOTS = 16;
  localparam int unsigned ENC_DONE_BITS = ENC_DONE_SLOTS * SLOT_BITS;
  localparam int unsigned DAC_DONE_SLOTS = 2;
  localparam int unsigned DAC_REFRESH_NS = 15000;
  localparam int unsigned CONV_CNT_W = 8;

  // Continuous control clock high for one frame selects fixed slot mode
  localparam int unsigned FIXED_HOLD_NS = 125000;
  localparam int unsigned FIXED_HOLD_CYC = (FIXED_HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned HOLD_CNT_W = 12;

  // ==========================================================
  // Control word
  localparam int unsigned CTRL_WORD_BITS = 8;
  localparam logic [3:0] CTRL_BITS_FULL = 4'h8;
  localparam logic [1:0] CMD_APPLY_FS = 2'h2;
  localparam logic [1:0] SEL_POWERDOWN = 2'h3;
  localparam logic [5:0] FIXED_SLOT = 6'h00;

  // Companding line inversion masks
  localparam logic [7:0] MU_LAW_MASK = 8'hFF;
  localparam logic [7:0] A_LAW_MASK = 8'h55;

  typedef enum logic [0:0] {
    PCMTSP_CS_IDLE = 1'b0,
    PCMTSP_CS_ARMED = 1'b1
  } pcmtsp_cs_e;

  // Line code from/to converter code; the inversion is its own inverse
  function automatic logic [7:0] pcmtsp_law(input logic [7:0] code, input logic mu_law);
    return code ^ (mu_law ? MU_LAW_MASK : A_LAW_MASK);
  endfunction

  // First bit-clock cycle of a slot, counted from the frame sync edge
  function automatic logic [10:0] pcmtsp_slot_start(input logic [5:0] slot);
    return SLOT_ONE_START + {2'h0, slot, 3'h0};
  endfunction

endpackage

// >>> pcmtsp_top.sv
/*
  Digital time-slot side of a single-channel PCM codec: transmit and
  receive serial ports on their own bit clocks, signaling bits, and a
  serial control port that assigns slots or powers the codec down.
  Assumes frame syncs are synchronous to their bit clocks and that the
  converter logic on both sides runs on the matching bit clock.
*/
// Contract
// - Control port assigns tx/rx slots or powerdown
// - Fixed slot mode without control words
// - Mu-law variant inserts and extracts signaling bits
// - A-law variant versus mu-law variant coding
// - Sample at slot end, send next frame
// - Encoding done within 16 slots
// - Decoder output changes within 2 slots
// - Decoder hold refreshed about 15 us later; the code makes one update only, at the lesser of 15 us and 2 slots
// - Receive bits MSB first on falling edges
// - Transmit output driven only during own slot
// - Signaling frame latches last received bit
// - Signaling output holds until changed or powerdown
// - Powerdown indicator high while powered down
// - Control word applies at second frame sync
// - Wide frame sync marks signaling frame
// - Transmit MSB first on rising edges
// - Fixed mode slot one after sync edge
`timescale 1ns/1ps

module pcmtsp_top #(
  parameter bit MU_LAW = 1'b1,
  parameter int unsigned BIT_PERIOD_NS = 488,
  parameter int unsigned FIXED_HOLD = pcmtsp_pkg::FIXED_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  input wire logic tx_signal_bit_in,
  input wire logic [7:0] encoder_code_in,
  output logic encoder_sample_strobe,
  output logic pcm_tx_out,
  output logic pcm_tx_oe,
  input wire logic rx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic pcm_rx_in,
  output logic rx_signal_bit_out,
  output logic [7:0] decoder_code_out,
  output logic decoder_update,
  input wire logic ctrl_shift_clock,
  input wire logic ctrl_serial_in,
  output logic powerdown_flag_out
);
  import pcmtsp_pkg::*;

  // Decoder update delay: about 15 us, never past two slots
  localparam int unsigned DAC_REFRESH_BITS = DAC_REFRESH_NS / BIT_PERIOD_NS;
  localparam int unsigned DAC_LIMIT_BITS = DAC_DONE_SLOTS * SLOT_BITS;
  localparam int unsigned DAC_BITS = (DAC_REFRESH_BITS < DAC_LIMIT_BITS) ? DAC_REFRESH_BITS : DAC_LIMIT_BITS;
  localparam logic [CONV_CNT_W-1:0] DAC_LOAD = CONV_CNT_W'(DAC_BITS);
  localparam logic [CONV_CNT_W-1:0] ENC_LOAD = CONV_CNT_W'(ENC_DONE_BITS);
  localparam logic [CONV_CNT_W-1:0] CONV_FIRE = 8'h01;
  localparam logic [HOLD_CNT_W-1:0] HOLD_MAX = HOLD_CNT_W'(FIXED_HOLD);

  // ==========================================================
  // Control domain (mclk): synchronisers
  logic cclk_s1_q, cclk_s2_q, cclk_prev_q;
  logic cdat_s1_q, cdat_s2_q;
  logic fs_tgl_s1_q, fs_tgl_s2_q, fs_tgl_prev_q, tx_fs_tgl_q;
  logic cclk_rise, cclk_fall, fs_evt;

  // Two flops on each pin and on the frame toggle from the tx domain
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cclk_s1_q <= 1'b0;
      cclk_s2_q <= 1'b0;
      cclk_prev_q <= 1'b0;
      cdat_s1_q <= 1'b0;
      cdat_s2_q <= 1'b0;
      fs_tgl_s1_q <= 1'b0;
      fs_tgl_s2_q <= 1'b0;
      fs_tgl_prev_q <= 1'b0;
    end else begin
      cclk_s1_q <= ctrl_shift_clock;
      cclk_s2_q <= cclk_s1_q;
      cclk_prev_q <= cclk_s2_q;
      cdat_s1_q <= ctrl_serial_in;
      cdat_s2_q <= cdat_s1_q;
      fs_tgl_s1_q <= tx_fs_tgl_q;
      fs_tgl_s2_q <= fs_tgl_s1_q;
      fs_tgl_prev_q <= fs_tgl_s2_q;
    end
  end

  assign cclk_rise = cclk_s2_q & ~cclk_prev_q;
  assign cclk_fall = ~cclk_s2_q & cclk_prev_q;
  assign fs_evt = fs_tgl_s2_q ^ fs_tgl_prev_q;

  // ==========================================================
  // Control domain: mode detection and word shifter
  logic [HOLD_CNT_W-1:0] hold_cnt_q;
  logic fixed_mode_q;
  logic [7:0] ctrl_sr_q;
  logic [3:0] ctrl_bits_q;
  pcmtsp_cs_e cs_q;
  logic [1:0] fs_seen_q;
  logic want_on;

  // A control clock held high for a frame selects fixed slot mode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hold_cnt_q <= '0;
      fixed_mode_q <= 1'b0;
    end else begin
      if (!cclk_s2_q) begin
        hold_cnt_q <= '0;
      end else if (hold_cnt_q != HOLD_MAX) begin
        hold_cnt_q <= hold_cnt_q + 1'b1;
      end
      fixed_mode_q <= cclk_s2_q & (hold_cnt_q == HOLD_MAX);
    end
  end

  // Control data shifts in on falling control clock edges, B1 first
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_sr_q <= '0;
      ctrl_bits_q <= '0;
    end else if (cs_q == PCMTSP_CS_IDLE && cclk_rise) begin
      ctrl_bits_q <= '0;
    end else if (cclk_fall && ctrl_bits_q != CTRL_BITS_FULL) begin
      ctrl_sr_q <= {ctrl_sr_q[6:0], cdat_s2_q};
      ctrl_bits_q <= ctrl_bits_q + 1'b1;
    end
  end

  // ==========================================================
  // Control domain: command sequencer and codec configuration
  logic [SLOT_W-1:0] cfg_tx_slot_q, cfg_rx_slot_q;
  logic cfg_tx_on_q, cfg_rx_on_q, cfg_tgl_q;

  // Fixed mode: a low data pin asks for power-up, high for power-down
  assign want_on = ~cdat_s2_q;

  // Arm on the first control pulse, act on the second frame sync
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs_q <= PCMTSP_CS_IDLE;
      fs_seen_q <= '0;
    end else begin
      unique case (cs_q)
        PCMTSP_CS_IDLE: begin
          fs_seen_q <= '0;
          if (fixed_mode_q ? (want_on != cfg_tx_on_q) : cclk_rise) begin
            cs_q <= PCMTSP_CS_ARMED;
          end
        end
        PCMTSP_CS_ARMED: begin
          if (fixed_mode_q && want_on == cfg_tx_on_q) begin
            cs_q <= PCMTSP_CS_IDLE; // Nothing to change yet: wait for the data pin
          end else if (fs_evt) begin
            fs_seen_q <= fs_seen_q + 1'b1;
            if (fs_seen_q + 1'b1 == CMD_APPLY_FS) begin
              cs_q <= PCMTSP_CS_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Configuration changes only at the applying frame sync
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_tx_slot_q <= FIXED_SLOT;
      cfg_rx_slot_q <= FIXED_SLOT;
      cfg_tx_on_q <= 1'b0;
      cfg_rx_on_q <= 1'b0;
      cfg_tgl_q <= 1'b0;
    end else if (cs_q == PCMTSP_CS_ARMED && fs_evt && fs_seen_q + 1'b1 == CMD_APPLY_FS) begin
      cfg_tgl_q <= ~cfg_tgl_q;
      if (fixed_mode_q) begin
        cfg_tx_slot_q <= FIXED_SLOT;
        cfg_rx_slot_q <= FIXED_SLOT;
        cfg_tx_on_q <= want_on;
        cfg_rx_on_q <= want_on;
      end else if (ctrl_bits_q == CTRL_BITS_FULL) begin
        if (ctrl_sr_q[7:6] == SEL_POWERDOWN) begin
          cfg_tx_on_q <= 1'b0;
          cfg_rx_on_q <= 1'b0;
        end else begin
          if (!ctrl_sr_q[7]) begin
            cfg_tx_slot_q <= ctrl_sr_q[5:0];
          end
          if (!ctrl_sr_q[6]) begin
            cfg_rx_slot_q <= ctrl_sr_q[5:0];
          end
          cfg_tx_on_q <= 1'b1;
          cfg_rx_on_q <= 1'b1;
        end
      end
    end
  end

  // Indicator follows the configured power state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      powerdown_flag_out <= 1'b1;
    end else begin
      powerdown_flag_out <= ~(cfg_tx_on_q | cfg_rx_on_q);
    end
  end

  // ==========================================================
  // Transmit domain (rising tx_bit_clock)
  logic tx_fs_prev_q, tx_sig_q;
  logic [BIT_CNT_W-1:0] tx_idx_q, tx_idx_d, tx_start, tx_off;
  logic tx_cfg_s1_q, tx_cfg_s2_q, tx_cfg_seen_q;
  logic [SLOT_W-1:0] tx_slot_q;
  logic tx_on_q, tx_inhibit_q, tx_fs_rise, tx_in_slot, tx_active, tx_bit, tx_drive;
  logic [7:0] tx_word_q;
  logic [CONV_CNT_W-1:0] enc_cnt_q;

  assign tx_fs_rise = tx_frame_sync & ~tx_fs_prev_q;
  assign tx_start = pcmtsp_slot_start(tx_slot_q);
  assign tx_off = tx_idx_d - tx_start;
  assign tx_in_slot = (tx_idx_d >= tx_start) && (tx_off < BIT_CNT_W'(SLOT_BITS));
  assign tx_active = tx_on_q & ~tx_inhibit_q;
  // A slot is driven whole: the driver only starts at its first bit
  assign tx_drive = tx_active & tx_in_slot & (pcm_tx_oe | (tx_off[2:0] == '0));

  // Cycle index within the frame, zero in the sync edge cycle
  always_comb begin
    if (tx_fs_rise) begin
      tx_idx_d = '0;
    end else if (tx_idx_q == BIT_CNT_MAX) begin
      tx_idx_d = tx_idx_q;
    end else begin
      tx_idx_d = tx_idx_q + 1'b1;
    end
  end

  // Bit to send: MSB first, signaling replaces the last bit
  always_comb begin
    tx_bit = tx_word_q[3'(SLOT_BITS - 1) - tx_off[2:0]];
    if (MU_LAW && tx_sig_q && tx_off[2:0] == LAST_BIT_OFF) begin
      tx_bit = tx_signal_bit_in;
    end
  end

  // Frame counting, signaling detection and frame toggle
  always_ff @(posedge tx_bit_clock or negedge rstn) begin
    if (!rstn) begin
      tx_fs_prev_q <= 1'b0;
      tx_idx_q <= BIT_CNT_MAX;
      tx_sig_q <= 1'b0;
      tx_fs_tgl_q <= 1'b0;
    end else begin
      tx_fs_prev_q <= tx_frame_sync;
      tx_idx_q <= tx_idx_d;
      if (tx_fs_rise) begin
        tx_sig_q <= 1'b0;
        tx_fs_tgl_q <= ~tx_fs_tgl_q;
      end else if (tx_idx_d == SIG_DETECT_IDX && tx_frame_sync) begin
        tx_sig_q <= 1'b1;
      end
    end
  end

  // Configuration handshake; first frame after power-up is muted
  always_ff @(posedge tx_bit_clock or negedge rstn) begin
    if (!rstn) begin
      tx_cfg_s1_q <= 1'b0;
      tx_cfg_s2_q <= 1'b0;
      tx_cfg_seen_q <= 1'b0;
      tx_slot_q <= FIXED_SLOT;
      tx_on_q <= 1'b0;
      tx_inhibit_q <= 1'b0;
    end else begin
      tx_cfg_s1_q <= cfg_tgl_q;
      tx_cfg_s2_q <= tx_cfg_s1_q;
      if (tx_cfg_s2_q != tx_cfg_seen_q && !tx_drive) begin // Never cut a slot short
        tx_cfg_seen_q <= tx_cfg_s2_q;
        tx_slot_q <= cfg_tx_slot_q;
        tx_on_q <= cfg_tx_on_q;
        if (cfg_tx_on_q && !tx_on_q) begin
          tx_inhibit_q <= 1'b1;
        end
      end else if (tx_fs_rise) begin
        tx_inhibit_q <= 1'b0;
      end
    end
  end

  // Output driver enabled only inside the assigned slot
  always_ff @(posedge tx_bit_clock or negedge rstn) begin
    if (!rstn) begin
      pcm_tx_oe <= 1'b0;
      pcm_tx_out <= 1'b0;
    end else begin
      pcm_tx_oe <= tx_drive;
      pcm_tx_out <= tx_drive ? tx_bit : 1'b0;
    end
  end

  // Sample at slot end, word ready within 16 slots for the next frame
  always_ff @(posedge tx_bit_clock or negedge rstn) begin
    if (!rstn) begin
      encoder_sample_strobe <= 1'b0;
      enc_cnt_q <= '0;
      tx_word_q <= MU_LAW ? MU_LAW_MASK : A_LAW_MASK;
    end else begin
      encoder_sample_strobe <= tx_on_q && tx_idx_d == tx_start + BIT_CNT_W'(SLOT_BITS);
      if (encoder_sample_strobe) begin
        enc_cnt_q <= ENC_LOAD;
      end else if (enc_cnt_q != '0) begin
        enc_cnt_q <= enc_cnt_q - 1'b1;
      end
      if (enc_cnt_q == CONV_FIRE) begin
        tx_word_q <= pcmtsp_law(encoder_code_in, MU_LAW);
      end
    end
  end

  // ==========================================================
  // Receive domain (falling rx_bit_clock)
  logic rx_fs_prev_q, rx_sig_q, rx_on_q, rx_inhibit_q;
  logic rx_cfg_s1_q, rx_cfg_s2_q, rx_cfg_seen_q;
  logic [SLOT_W-1:0] rx_slot_q;
  logic [BIT_CNT_W-1:0] rx_idx_q, rx_idx_d, rx_start, rx_off;
  logic rx_fs_rise, rx_in_slot, rx_last;
  logic [7:0] rx_sr_q, rx_word_q;
  logic [CONV_CNT_W-1:0] dac_cnt_q;

  assign rx_fs_rise = rx_frame_sync & ~rx_fs_prev_q;
  assign rx_start = pcmtsp_slot_start(rx_slot_q);
  assign rx_off = rx_idx_d - rx_start;
  assign rx_in_slot = rx_on_q && !rx_inhibit_q && (rx_idx_d >= rx_start) && (rx_off < BIT_CNT_W'(SLOT_BITS));
  assign rx_last = rx_in_slot && rx_off[2:0] == LAST_BIT_OFF;

  // Cycle index within the receive frame
  always_comb begin
    if (rx_fs_rise) begin
      rx_idx_d = '0;
    end else if (rx_idx_q == BIT_CNT_MAX) begin
      rx_idx_d = rx_idx_q;
    end else begin
      rx_idx_d = rx_idx_q + 1'b1;
    end
  end

  // Frame counting and signaling frame detection
  always_ff @(negedge rx_bit_clock or negedge rstn) begin
    if (!rstn) begin
      rx_fs_prev_q <= 1'b0;
      rx_idx_q <= BIT_CNT_MAX;
      rx_sig_q <= 1'b0;
    end else begin
      rx_fs_prev_q <= rx_frame_sync;
      rx_idx_q <= rx_idx_d;
      if (rx_fs_rise) begin
        rx_sig_q <= 1'b0;
      end else if (rx_idx_d == SIG_DETECT_IDX && rx_frame_sync) begin
        rx_sig_q <= 1'b1;
      end
    end
  end

  // Configuration handshake; first frame after power-up is ignored
  always_ff @(negedge rx_bit_clock or negedge rstn) begin
    if (!rstn) begin
      rx_cfg_s1_q <= 1'b0;
      rx_cfg_s2_q <= 1'b0;
      rx_cfg_seen_q <= 1'b0;
      rx_slot_q <= FIXED_SLOT;
      rx_on_q <= 1'b0;
      rx_inhibit_q <= 1'b0;
    end else begin
      rx_cfg_s1_q <= cfg_tgl_q;
      rx_cfg_s2_q <= rx_cfg_s1_q;
      if (rx_cfg_s2_q != rx_cfg_seen_q) begin
        rx_cfg_seen_q <= rx_cfg_s2_q;
        rx_slot_q <= cfg_rx_slot_q;
        rx_on_q <= cfg_rx_on_q;
        if (cfg_rx_on_q && !rx_on_q) begin
          rx_inhibit_q <= 1'b1;
        end
      end else if (rx_fs_rise) begin
        rx_inhibit_q <= 1'b0;
      end
    end
  end

  // Shift in MSB first; latch word and signaling bit on the last bit
  always_ff @(negedge rx_bit_clock or negedge rstn) begin
    if (!rstn) begin
      rx_sr_q <= '0;
      rx_word_q <= '0;
      rx_signal_bit_out <= 1'b0;
    end else begin
      if (rx_in_slot) begin
        rx_sr_q <= {rx_sr_q[6:0], pcm_rx_in};
      end
      if (rx_last) begin
        rx_word_q <= {rx_sr_q[6:0], pcm_rx_in};
      end
      if (!rx_on_q) begin
        rx_signal_bit_out <= 1'b0;
      end else if (MU_LAW && rx_sig_q && rx_last) begin
        rx_signal_bit_out <= pcm_rx_in;
      end
    end
  end

  // Decoder output refresh a fixed delay after the slot ends
  always_ff @(negedge rx_bit_clock or negedge rstn) begin
    if (!rstn) begin
      dac_cnt_q <= '0;
      decoder_code_out <= '0;
      decoder_update <= 1'b0;
    end else begin
      decoder_update <= 1'b0;
      if (rx_last) begin
        dac_cnt_q <= DAC_LOAD;
      end else if (dac_cnt_q != '0) begin
        dac_cnt_q <= dac_cnt_q - 1'b1;
      end
      if (dac_cnt_q == CONV_FIRE) begin
        decoder_code_out <= pcmtsp_law(rx_word_q, MU_LAW);
        decoder_update <= 1'b1;
      end
    end
  end

endmodule

// >>> pcmtsp_assertions.sv
/*
  Checker for the PCM time-slot port top ports.
  Assumes binding to the top; rstn resets all domains.
*/
`timescale 1ns/1ps
module pcmtsp_assertions (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  input wire logic rx_bit_clock,
  input wire logic pcm_tx_out,
  input wire logic pcm_tx_oe,
  input wire logic encoder_sample_strobe,
  input wire logic decoder_update,
  input wire logic [7:0] decoder_code_out,
  input wire logic rx_signal_bit_out,
  input wire logic powerdown_flag_out
);
  logic [7:0] since_fs_q;

  // ==========
  // Mclk cycles since a tx frame sync was seen
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      since_fs_q <= 8'hFF;
    end else if (tx_frame_sync) begin
      since_fs_q <= 8'h00;
    end else if (since_fs_q != 8'hFF) begin
      since_fs_q <= since_fs_q + 8'h01;
    end
  end

  // ==========
  // Transmit and control relations
  oe_one_slot_a: assert property (@(posedge tx_bit_clock) disable iff (!rstn)
    $rose(pcm_tx_oe) |-> pcm_tx_oe [*8] ##1 !pcm_tx_oe) else $error("drive window not 8 bits");
  oe_idle_low_a: assert property (@(posedge tx_bit_clock) disable iff (!rstn)
    !pcm_tx_oe |-> !pcm_tx_out) else $error("tx data high outside window");
  pdn_no_drive_a: assert property (@(posedge tx_bit_clock) disable iff (!rstn)
    powerdown_flag_out [*8] |-> !pcm_tx_oe) else $error("tx driven in powerdown");
  strobe_at_end_a: assert property (@(posedge tx_bit_clock) disable iff (!rstn)
    $fell(pcm_tx_oe) |-> encoder_sample_strobe ##1 !encoder_sample_strobe) else $error("no strobe at slot end");
  pdn_at_sync_a: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(powerdown_flag_out) |-> since_fs_q < 8'h10) else $error("powerdown moved off frame sync");

  // ==========
  // Receive relations
  dec_pulse_a: assert property (@(negedge rx_bit_clock) disable iff (!rstn)
    decoder_update |=> !decoder_update) else $error("decoder update too long");
  dec_change_a: assert property (@(negedge rx_bit_clock) disable iff (!rstn)
    $changed(decoder_code_out) |-> decoder_update) else $error("decoder code moved silently");
  sig_powered_a: assert property (@(negedge rx_bit_clock) disable iff (!rstn)
    $rose(rx_signal_bit_out) |-> !powerdown_flag_out) else $error("signal bit set in powerdown");
endmodule

// >>> pcmtsp_far_end.sv
/*
  Far end: highway bit clocks, frame syncs, receive data, tx capture.
  Assumes controls change well inside a frame; bit clocks run free.
*/
`timescale 1ns/1ps
module pcmtsp_far_end #(
  parameter int FRAME = 260
) (
  input wire logic wide_fs,
  input wire logic [5:0] rx_slot,
  input wire logic [7:0] rx_word,
  input wire logic pcm_tx_out,
  input wire logic pcm_tx_oe,
  output logic tx_bit_clock,
  output logic tx_frame_sync,
  output logic rx_bit_clock,
  output logic rx_frame_sync,
  output logic pcm_rx_in,
  output logic [7:0] tx_word_q,
  output logic [8:0] tx_first_q,
  output logic [3:0] tx_count_q
);
  logic [8:0] tc_q = 9'h000;
  logic [8:0] rc_q = 9'h000;
  logic [8:0] first_q;
  logic [7:0] word_q;
  logic [3:0] cnt_q = 4'h0;
  int b;

  // ==========
  // Bit clocks of 125 ns, unrelated in phase
  initial begin
    tx_frame_sync = 1'b0;
    rx_frame_sync = 1'b0;
    pcm_rx_in = 1'b0;
    tx_bit_clock = 1'b0;
    forever #62.5 tx_bit_clock = ~tx_bit_clock;
  end
  initial begin
    rx_bit_clock = 1'b0;
    #37;
    forever #62.5 rx_bit_clock = ~rx_bit_clock;
  end

  // Tx frame count; sync held two cycles marks signaling
  always @(posedge tx_bit_clock) begin
    tc_q <= (tc_q == 9'(FRAME - 1)) ? 9'h000 : tc_q + 9'h001;
    tx_frame_sync <= (tc_q == 9'(FRAME - 1)) || (wide_fs && tc_q == 9'h000);
  end

  // Tx capture on falling edges; each frame reported early in the next
  always @(negedge tx_bit_clock) begin
    if (tc_q == 9'h001) begin
      tx_word_q <= word_q;
      tx_first_q <= first_q;
      tx_count_q <= cnt_q;
      cnt_q <= 4'h0;
    end else if (pcm_tx_oe) begin
      if (cnt_q == 4'h0) begin
        first_q <= tc_q;
      end
      word_q <= {word_q[6:0], pcm_tx_out};
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Rx sync and slot bits, MSB first; line toggles outside the slot
  always @(posedge rx_bit_clock) begin
    rc_q <= (rc_q == 9'(FRAME - 1)) ? 9'h000 : rc_q + 9'h001;
    rx_frame_sync <= (rc_q == 9'(FRAME - 1)) || (wide_fs && rc_q == 9'h000);
    b = int'(rc_q) - 8 * int'(rx_slot);
    if (b >= 0 && b < 8) begin
      pcm_rx_in <= rx_word[7 - b];
    end else begin
      pcm_rx_in <= ~pcm_rx_in;
    end
  end
endmodule

// >>> pcmtsp_top_tb.sv
/*
  Self-checking bench for the PCM time-slot port top.
  Assumes the far end model makes bit clocks and frame syncs.
*/
`timescale 1ns/1ps
module pcmtsp_top_tb;
  localparam int FIXED_HOLD = 20;
  logic mclk, rstn, tx_bit_clock, tx_frame_sync, tx_signal_bit_in, encoder_sample_strobe;
  logic pcm_tx_out, pcm_tx_oe, rx_bit_clock, rx_frame_sync, pcm_rx_in, rx_signal_bit_out;
  logic decoder_update, ctrl_shift_clock, ctrl_serial_in, powerdown_flag_out, wide_fs, alaw_sig;
  logic [7:0] encoder_code_in, decoder_code_out, rx_word, tx_word_q, alaw_code;
  logic [5:0] rx_slot;
  logic [8:0] tx_first_q;
  logic [3:0] tx_count_q;
  int failures = 0;
  int check_count = 0;

  pcmtsp_top #(.MU_LAW(1'b1), .BIT_PERIOD_NS(125), .FIXED_HOLD(FIXED_HOLD)) i_dut (
    .mclk(mclk), .rstn(rstn), .tx_bit_clock(tx_bit_clock), .tx_frame_sync(tx_frame_sync),
    .tx_signal_bit_in(tx_signal_bit_in), .encoder_code_in(encoder_code_in),
    .encoder_sample_strobe(encoder_sample_strobe), .pcm_tx_out(pcm_tx_out), .pcm_tx_oe(pcm_tx_oe),
    .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync), .pcm_rx_in(pcm_rx_in),
    .rx_signal_bit_out(rx_signal_bit_out), .decoder_code_out(decoder_code_out),
    .decoder_update(decoder_update), .ctrl_shift_clock(ctrl_shift_clock),
    .ctrl_serial_in(ctrl_serial_in), .powerdown_flag_out(powerdown_flag_out));

  // A-law twin shares the links; only its receive side is judged
  pcmtsp_top #(.MU_LAW(1'b0), .BIT_PERIOD_NS(125), .FIXED_HOLD(FIXED_HOLD)) i_dut_alaw (
    .mclk(mclk), .rstn(rstn), .tx_bit_clock(tx_bit_clock), .tx_frame_sync(tx_frame_sync),
    .tx_signal_bit_in(tx_signal_bit_in), .encoder_code_in(encoder_code_in), .encoder_sample_strobe(),
    .pcm_tx_out(), .pcm_tx_oe(), .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
    .pcm_rx_in(pcm_rx_in), .rx_signal_bit_out(alaw_sig), .decoder_code_out(alaw_code), .decoder_update(),
    .ctrl_shift_clock(ctrl_shift_clock), .ctrl_serial_in(ctrl_serial_in), .powerdown_flag_out());

  pcmtsp_far_end i_far (.wide_fs(wide_fs), .rx_slot(rx_slot), .rx_word(rx_word),
    .pcm_tx_out(pcm_tx_out), .pcm_tx_oe(pcm_tx_oe), .tx_bit_clock(tx_bit_clock),
    .tx_frame_sync(tx_frame_sync), .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
    .pcm_rx_in(pcm_rx_in), .tx_word_q(tx_word_q), .tx_first_q(tx_first_q), .tx_count_q(tx_count_q));

  // ==========
  // Shared tasks
  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      failures++;
      $display("unexpected at %0t ns: %s", $time, msg);
    end
  endtask
  // Waits frame syncs, then lets the far end publish its capture
  task automatic frames(input int n);
    repeat (n) @(posedge tx_frame_sync);
    repeat (3) @(posedge mclk);
  endtask
  task automatic wait_apply(input logic old_pdn);
    frames(1);
    repeat (20) @(posedge mclk);
    chk(powerdown_flag_out === old_pdn, "command applied at first sync");
    frames(1);
    repeat (20) @(posedge mclk);
  endtask
  // Control word B1 first, one bit per falling control edge
  task automatic apply(input logic [7:0] w, input logic old_pdn);
    frames(1);
    for (int i = 7; i >= 0; i--) begin
      ctrl_serial_in <= w[i];
      ctrl_shift_clock <= 1'b1;
      repeat (3) @(posedge mclk);
      ctrl_shift_clock <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    wait_apply(old_pdn);
  endtask
  task automatic slot_is(input logic [8:0] first, input logic [7:0] word, input string msg);
    chk(tx_count_q === 4'h8 && tx_first_q === first && tx_word_q === word, msg);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========
  // Scenarios
  task automatic t_assign();
    chk(pcm_tx_oe === 1'b0 && powerdown_flag_out === 1'b1, "not idle after reset");
    chk(rx_signal_bit_out === 1'b0 && decoder_code_out === 8'h00, "rx outputs set");
    apply(8'h03, 1'b1);
    chk(powerdown_flag_out === 1'b0, "no power up");
    frames(1);
    chk(tx_count_q === 4'h0, "tx driven in activation frame");
    frames(2);
    slot_is(9'h01A, 8'hC3, "slot 3 word wrong");
    chk(decoder_code_out === 8'h5B, "decoder code wrong");
    chk(alaw_code === 8'hF1, "a-law decoder code wrong");
    encoder_code_in <= 8'h96;
    frames(2);
    slot_is(9'h01A, 8'h69, "new sample late");
    $display("test assign done");
  endtask
  task automatic t_signal();
    wide_fs <= 1'b1;
    rx_word <= 8'hA5;
    frames(2);
    slot_is(9'h01A, 8'h68, "signal bit not sent");
    chk(rx_signal_bit_out === 1'b1 && alaw_sig === 1'b0, "signal bit not latched");
    wide_fs <= 1'b0;
    frames(2);
    rx_word <= 8'hA4;
    frames(2);
    slot_is(9'h01A, 8'h69, "pcm bit not restored");
    chk(rx_signal_bit_out === 1'b1 && decoder_code_out === 8'h5B, "signal bit lost");
    $display("test signal done");
  endtask
  task automatic t_tx_only();
    rx_word <= 8'h0F;
    apply(8'h5F, 1'b0);
    frames(2);
    slot_is(9'h0FA, 8'h69, "tx slot 31 wrong");
    chk(decoder_code_out === 8'hF0, "rx slot moved");
    $display("test tx only done");
  endtask
  task automatic t_powerdown();
    apply(8'hC0, 1'b0);
    chk(powerdown_flag_out === 1'b1 && rx_signal_bit_out === 1'b0, "powerdown wrong");
    frames(2);
    chk(tx_count_q === 4'h0, "tx driven in powerdown");
    $display("test powerdown done");
  endtask
  task automatic t_fixed();
    rx_slot <= 6'h00;
    rx_word <= 8'h81;
    ctrl_serial_in <= 1'b1;
    ctrl_shift_clock <= 1'b1;
    repeat (FIXED_HOLD + 10) @(posedge mclk);
    frames(1);
    ctrl_serial_in <= 1'b0;
    wait_apply(1'b1);
    chk(powerdown_flag_out === 1'b0, "fixed mode no power up");
    frames(3);
    slot_is(9'h002, 8'h69, "fixed slot one wrong");
    chk(decoder_code_out === 8'h7E, "fixed rx slot wrong");
    ctrl_serial_in <= 1'b1;
    wait_apply(1'b0);
    chk(powerdown_flag_out === 1'b1, "fixed mode no power down");
    $display("test fixed done");
  endtask

  // ==========
  // Clock, reset, sequence and watchdog
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    rstn = 1'b0;
    tx_signal_bit_in = 1'b0;
    encoder_code_in = 8'h3C;
    ctrl_shift_clock = 1'b0;
    ctrl_serial_in = 1'b0;
    wide_fs = 1'b0;
    rx_slot = 6'h03;
    rx_word = 8'hA4;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    t_assign();
    t_signal();
    t_tx_only();
    t_powerdown();
    t_fixed();
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    $display("unexpected at %0t ns: watchdog", $time);
    tally_and_finish();
  end
endmodule

bind pcmtsp_top pcmtsp_assertions i_chk (.mclk(mclk), .rstn(rstn), .tx_bit_clock(tx_bit_clock),
  .tx_frame_sync(tx_frame_sync), .rx_bit_clock(rx_bit_clock), .pcm_tx_out(pcm_tx_out),
  .pcm_tx_oe(pcm_tx_oe), .encoder_sample_strobe(encoder_sample_strobe), .decoder_update(decoder_update),
  .decoder_code_out(decoder_code_out), .rx_signal_bit_out(rx_signal_bit_out),
  .powerdown_flag_out(powerdown_flag_out));
